// ===== rtl/ppm_pkg.sv
// Package: constants for the parallel port pin multiplexer
package ppm_pkg;
  localparam int ADDR_W = 19;
  localparam int HOST_ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int SYNC_STAGES = 2;
  localparam logic RST_HOLDER_EN = 1'b0;
  localparam logic RST_MODE_EXT = 1'b0;
  localparam logic [18:0] RST_ADDR = 19'h00000;
  localparam logic [15:0] RST_DATA = 16'h0000;
  localparam int ADDR_TOP_BIT = 18;
endpackage : ppm_pkg

// ===== rtl/ppm_sync.sv
// Two-flop synchroniser for a vector of pin inputs
`timescale 1ns/100ps
module ppm_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } ppm_sync_state_t;

  ppm_sync_state_t state_reg;
  ppm_sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next = state_reg;
    state_next.stage1 = async_in;
    state_next.stage2 = state_reg.stage1;
  end

  // Register the state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stage2;
endmodule : ppm_sync

// ===== rtl/ppm_pin_mux.sv
// Parallel port pin multiplexer: memory mode, host mode, holders, off
//------------------------------------------------------------------------
// Summary of operation
// [R1] Memory mode (select high): drive all nineteen address lines.
// [R2] Top address line is the secondary output on the subsystem select pin.
// [R3] Host mode: host drives lower eighteen address lines; device takes them.
// [R4] Outputs-off low floats address and data lines.
// [R5] Memory mode: data driven on writes, sampled on reads.
// [R6] Host mode: data lines are the sixteen-bit host data bus.
// [R7] Memory mode, holders enabled and undriven: data pins keep last driven level.
// [R8] Holders disabled after reset; software sets or clears enable bit.
// [R9] Holder enable bit lives in first subsystem's bank switch control.
// [R10] Mode select is static; host mode never drives address lines.
// [R11] Host mode drives data only during a host read.
//------------------------------------------------------------------------
`timescale 1ns/100ps
module ppm_pin_mux
  import ppm_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int HAW = HOST_ADDR_W,
  parameter int DW = DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic port_mode_select,
  input wire logic outputs_off_n,
  input wire logic [AW-1:0] mem_addr,
  input wire logic mem_write,
  input wire logic [DW-1:0] mem_wdata,
  output logic [DW-1:0] mem_rdata,
  input wire logic holder_wr,
  input wire logic holder_wdata,
  output logic holder_enable_bit,
  input wire logic host_read,
  input wire logic [DW-1:0] host_rdata,
  output logic [HAW-1:0] host_addr,
  output logic [DW-1:0] host_wdata,
  output logic external_memory_mode,
  input wire logic [AW-1:0] parallel_port_address_in,
  output logic [AW-1:0] parallel_port_address_out,
  output logic [AW-1:0] parallel_port_address_oe,
  input wire logic [DW-1:0] parallel_port_data_in,
  output logic [DW-1:0] parallel_port_data_out,
  output logic [DW-1:0] parallel_port_data_oe
);
  //----------------------------------------------------------------------
  // Pin synchronisers
  //----------------------------------------------------------------------
  localparam int SW = 2 + AW + DW;
  logic [SW-1:0] pins_sync;
  logic mode_s;
  logic off_n_s;
  logic [AW-1:0] addr_s;
  logic [DW-1:0] data_s;

  ppm_sync #(.WIDTH(SW)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in({port_mode_select, outputs_off_n,
               parallel_port_address_in, parallel_port_data_in}),
    .sync_out(pins_sync)
  );

  // Split the synchronised pin vector
  assign {mode_s, off_n_s, addr_s, data_s} = pins_sync;

  //----------------------------------------------------------------------
  // State
  //----------------------------------------------------------------------
  typedef struct packed {
    logic mode_ext;
    logic mode_valid;
    logic [1:0] settle;
    logic holder_en;
    logic [DW-1:0] last_drv;
    logic [AW-1:0] a_out;
    logic [AW-1:0] a_oe;
    logic [DW-1:0] d_out;
    logic [DW-1:0] d_oe;
    logic [DW-1:0] rdata;
    logic [HAW-1:0] h_addr;
    logic [DW-1:0] h_wdata;
  } ppm_state_t;

  ppm_state_t state_reg;
  ppm_state_t state_next;

  // Holder drive: keeps the last driven level while enabled
  function automatic logic [DW-1:0] holder_oe(input logic en);
    holder_oe = en ? {DW{1'b1}} : {DW{1'b0}};
  endfunction : holder_oe

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    // Let the cleared pin synchroniser refill after reset, then capture
    // the mode once and keep it static
    if (!state_reg.mode_valid) begin
      if (state_reg.settle == 2'(SYNC_STAGES)) begin
        state_next.mode_ext = mode_s; // [R10]
        state_next.mode_valid = 1'b1;
      end else begin
        state_next.settle = state_reg.settle + 2'h1;
      end
    end
    // Holder enable bit write
    if (holder_wr) begin
      state_next.holder_en = holder_wdata; // [R8] [R9]
    end
    state_next.a_oe = '0;
    state_next.d_oe = '0;
    state_next.d_out = state_reg.last_drv;
    if (state_reg.mode_valid && state_reg.mode_ext) begin
      // Memory mode: all address lines driven, top one on select pin
      state_next.a_out = mem_addr; // [R1] [R2]
      state_next.a_oe = {AW{1'b1}}; // [R1]
      if (mem_write) begin
        state_next.d_out = mem_wdata; // [R5]
        state_next.d_oe = {DW{1'b1}};
        state_next.last_drv = mem_wdata;
      end else begin
        state_next.rdata = data_s; // [R5]
      end
    end else if (state_reg.mode_valid) begin
      // Host mode: address in, data both ways
      state_next.h_addr = addr_s[HAW-1:0]; // [R3] [R10]
      if (host_read) begin
        state_next.d_out = host_rdata; // [R6] [R11]
        state_next.d_oe = {DW{1'b1}};
        state_next.last_drv = host_rdata;
      end else begin
        state_next.h_wdata = data_s; // [R6]
      end
    end
    // Undriven data lines fall back on the holders in memory mode only;
    // host mode must release the data lines outside host reads
    if (state_next.d_oe == '0 && state_reg.mode_ext) begin
      state_next.d_out = state_reg.last_drv; // [R7]
      state_next.d_oe = holder_oe(state_next.holder_en); // [R7]
    end
    // Outputs off overrides both the address and the data output enables
    if (!off_n_s) begin
      state_next.a_oe = '0; // [R4]
      state_next.d_oe = '0; // [R4]
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_reg <= '0;
      state_reg.mode_ext <= RST_MODE_EXT;
      state_reg.holder_en <= RST_HOLDER_EN; // [R8]
      state_reg.a_out <= RST_ADDR;
      state_reg.d_out <= RST_DATA;
    end else begin
      state_reg <= state_next;
    end
  end

  //----------------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------------
  assign parallel_port_address_out = state_reg.a_out;
  assign parallel_port_address_oe = state_reg.a_oe;
  assign parallel_port_data_out = state_reg.d_out;
  assign parallel_port_data_oe = state_reg.d_oe;
  assign mem_rdata = state_reg.rdata;
  assign host_addr = state_reg.h_addr;
  assign host_wdata = state_reg.h_wdata;
  assign holder_enable_bit = state_reg.holder_en;
  assign external_memory_mode = state_reg.mode_ext;

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------
  sequence s_off_seen;
    !off_n_s;
  endsequence

  property p_off_float;
    @(posedge clk_sys) disable iff (reset)
      s_off_seen |=> (parallel_port_address_oe == '0 &&
                      parallel_port_data_oe == '0);
  endproperty
  a_off_float: assert property (p_off_float) // [R4]
    else $error("outputs not floated while off");

  property p_mem_addr;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && state_reg.mode_ext && off_n_s)
        |=> (parallel_port_address_oe == {AW{1'b1}} &&
             parallel_port_address_out == $past(mem_addr));
  endproperty
  a_mem_addr: assert property (p_mem_addr) // [R1]
    else $error("memory mode address not driven");

  property p_host_no_addr;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && !state_reg.mode_ext)
        |=> parallel_port_address_oe == '0;
  endproperty
  a_host_no_addr: assert property (p_host_no_addr) // [R10]
    else $error("address driven in host mode");

  property p_host_read;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && !state_reg.mode_ext && host_read && off_n_s)
        |=> (parallel_port_data_oe == {DW{1'b1}} &&
             parallel_port_data_out == $past(host_rdata));
  endproperty
  a_host_read: assert property (p_host_read) // [R11]
    else $error("host read data not driven");

  property p_host_release;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && !state_reg.mode_ext && !host_read)
        |=> parallel_port_data_oe == '0;
  endproperty
  a_host_release: assert property (p_host_release) // [R11]
    else $error("data driven outside host read");

  property p_mem_write;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && state_reg.mode_ext && mem_write && off_n_s)
        |=> parallel_port_data_out == $past(mem_wdata);
  endproperty
  a_mem_write: assert property (p_mem_write) // [R5]
    else $error("memory write data not driven");

  property p_holder_keep;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && state_reg.mode_ext && !mem_write &&
       off_n_s && state_next.holder_en)
        |=> (parallel_port_data_out == $past(state_reg.last_drv) &&
             parallel_port_data_oe == {DW{1'b1}});
  endproperty
  a_holder_keep: assert property (p_holder_keep) // [R7]
    else $error("holder lost last level");

  property p_holder_reset;
    @(posedge clk_sys) reset |=> !holder_enable_bit;
  endproperty
  a_holder_reset: assert property (p_holder_reset) // [R8]
    else $error("holder enabled after reset");

  property p_host_addr;
    @(posedge clk_sys) disable iff (reset)
      (state_reg.mode_valid && !state_reg.mode_ext)
        |=> host_addr == $past(addr_s[HAW-1:0]);
  endproperty
  a_host_addr: assert property (p_host_addr) // [R3]
    else $error("host address not taken");
endmodule : ppm_pin_mux

// ===== verif/ppm_far_end.sv
// Far-side model: async memory or host on the parallel port pins
`timescale 1ns/100ps
module ppm_far_end (
  input wire logic clk_sys,
  input wire logic host_mode,
  input wire logic host_reading,
  input wire logic [17:0] host_addr_val,
  input wire logic [15:0] far_data_val,
  input wire logic [18:0] addr_out,
  input wire logic [18:0] addr_oe,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe,
  output logic [18:0] addr_pin,
  output logic [15:0] data_pin
);
  logic [18:0] addr_last = '0;
  logic [15:0] data_last = '0;
  // Resolve each wire; a line nobody drives flips away from its last level
  always_comb begin
    for (int i = 0; i < 19; i++) begin
      if (addr_oe[i]) addr_pin[i] = addr_out[i];
      else if (host_mode && i < 18) addr_pin[i] = host_addr_val[i];
      else addr_pin[i] = ~addr_last[i];
    end
    for (int i = 0; i < 16; i++) begin
      if (data_oe[i]) data_pin[i] = data_out[i];
      else if (!host_reading) data_pin[i] = far_data_val[i];
      else data_pin[i] = ~data_last[i];
    end
  end
  // Remember last wire levels
  always_ff @(posedge clk_sys) begin
    addr_last <= addr_pin;
    data_last <= data_pin;
  end
endmodule : ppm_far_end

// ===== verif/ppm_pin_mux_tb.sv
// Testbench for the parallel port pin multiplexer
`timescale 1ns/100ps
module ppm_pin_mux_tb;
  logic clk_sys = 0, reset = 1, port_mode_select = 1, outputs_off_n = 1;
  logic mem_write = 0, holder_wr = 0, holder_wdata = 0, host_read = 0;
  logic [18:0] mem_addr = '0, addr_out, addr_oe, addr_pin;
  logic [15:0] mem_wdata = '0, host_rdata = '0, far_data_val = '0;
  logic [15:0] mem_rdata, host_wdata, data_out, data_oe, data_pin;
  logic [17:0] host_addr_val = '0, host_addr;
  logic holder_enable_bit, external_memory_mode;
  int fail_count = 0, n_tests = 0, cyc_count = 0;
  always #20 clk_sys = ~clk_sys;
  ppm_pin_mux ppm_pin_mux_inst (.clk_sys, .reset, .port_mode_select,
    .outputs_off_n, .mem_addr, .mem_write, .mem_wdata, .mem_rdata,
    .holder_wr, .holder_wdata, .holder_enable_bit, .host_read, .host_rdata,
    .host_addr, .host_wdata, .external_memory_mode,
    .parallel_port_address_in(addr_pin), .parallel_port_address_out(addr_out),
    .parallel_port_address_oe(addr_oe), .parallel_port_data_in(data_pin),
    .parallel_port_data_out(data_out), .parallel_port_data_oe(data_oe));
  ppm_far_end ppm_far_end_inst (.clk_sys, .host_mode(!port_mode_select),
    .host_reading(host_read), .host_addr_val, .far_data_val, .addr_out,
    .addr_oe, .data_out, .data_oe, .addr_pin, .data_pin);
  //----------------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic do_reset(input logic mode);
    port_mode_select = mode;
    reset = 1;
    cyc(5);
    reset = 0;
    cyc(4);
  endtask : do_reset
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // Memory mode: write, read of far-end data, holder, outputs off
  task automatic t_mem();
    do_reset(1);
    chk("holder_rst", holder_enable_bit, 0);
    chk("mode_mem", external_memory_mode, 1);
    mem_addr = 19'h4A5C3;
    mem_wdata = 16'hC3A5;
    mem_write = 1;
    cyc(1);
    chk("addr_out", addr_out, 19'h4A5C3);
    chk("addr_oe", addr_oe, 19'h7FFFF);
    chk("wr_oe", data_oe, 16'hFFFF);
    chk("wr_data", data_out, 16'hC3A5);
    mem_write = 0;
    far_data_val = 16'h5A0F;
    cyc(1);
    chk("rd_oe", data_oe, 16'h0000);
    cyc(4);
    chk("rd_data", mem_rdata, 16'h5A0F);
    holder_wr = 1;
    holder_wdata = 1;
    cyc(1);
    holder_wr = 0;
    cyc(2);
    chk("holder_on", holder_enable_bit, 1);
    chk("hold_val", data_out, 16'hC3A5);
    mem_write = 1;
    outputs_off_n = 0;
    cyc(4);
    chk("off_addr", addr_oe, 19'h00000);
    chk("off_data", data_oe, 16'h0000);
    outputs_off_n = 1;
    cyc(4);
    chk("on_addr", addr_oe, 19'h7FFFF);
    mem_write = 0;
  endtask : t_mem
  // Host mode: address and data in, read out, mode stays put
  task automatic t_host();
    do_reset(0);
    host_addr_val = 18'h25A3C;
    far_data_val = 16'h9E71;
    cyc(4);
    chk("holder_rst2", holder_enable_bit, 0);
    chk("host_aoe", addr_oe, 19'h00000);
    chk("host_addr", host_addr, 18'h25A3C);
    chk("host_wdata", host_wdata, 16'h9E71);
    chk("idle_doe", data_oe, 16'h0000);
    host_rdata = 16'hB00F;
    host_read = 1;
    cyc(1);
    chk("hrd_oe", data_oe, 16'hFFFF);
    chk("hrd_data", data_out, 16'hB00F);
    host_read = 0;
    cyc(1);
    chk("hrd_end", data_oe, 16'h0000);
    holder_wr = 1;
    holder_wdata = 1;
    cyc(1);
    holder_wr = 0;
    cyc(1);
    chk("host_holder", holder_enable_bit, 1);
    chk("host_hold_oe", data_oe, 16'h0000);
    port_mode_select = 1;
    cyc(4);
    chk("mode_static", external_memory_mode, 0);
    chk("static_aoe", addr_oe, 19'h00000);
  endtask : t_host
  // Hang guard
  always @(posedge clk_sys) begin
    cyc_count++;
    if (cyc_count == 2000) begin
      fail_count++;
      test_done();
    end
  end
  initial begin
    t_mem();
    t_host();
    test_done();
  end
endmodule : ppm_pin_mux_tb
